// ==== logic/xac_pkg.sv ====
package xac_pkg;

	// ****************************************
	// Address space
	// ****************************************
	localparam int ADDR_W = 20;
	localparam int WORD_W = 16;
	localparam logic [19:0] SP_RESET = 20'h00a00;
	localparam logic [19:0] PC_RESET = 20'h00000;
	localparam logic [19:0] STACK_STEP = 20'h00002;
	localparam logic [3:0] PC_HI_ZERO = 4'h0;
	localparam int PC_HI_LSB = 16;
	localparam int SR_PCHI_LSB = 12;

	// ****************************************
	// Vector table
	// ****************************************
	localparam logic [19:0] BOOT_RSVD_ADDR = 20'h0ffbe;
	localparam logic [19:0] VEC_BASE_ADDR = BOOT_RSVD_ADDR + 20'h00002;
	localparam int VEC_COUNT = 32;
	localparam int VEC_NUM_W = 5;

	// ****************************************
	// Information flash
	// ****************************************
	localparam logic [15:0] INFO_BASE = 16'h1000;
	localparam logic [15:0] INFO_LAST = 16'h10ff;
	localparam int INFO_SEG_BYTES = 64;
	localparam int INFO_SEG_W = 2;
	localparam int INFO_OFS_W = 6;
	localparam logic [1:0] SEG_D = 2'h0;
	localparam logic [1:0] SEG_C = 2'h1;
	localparam logic [1:0] SEG_B = 2'h2;
	localparam logic [1:0] SEG_A = 2'h3;
	// Arbitrary key value
	localparam logic [15:0] UNLOCK_KEY = 16'h5a3c;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_NEAR_CALL = 4'h1,
		OP_FAR_CALL = 4'h2,
		OP_NEAR_RET = 4'h3,
		OP_FAR_RET = 4'h4,
		OP_MOV_W_PC = 4'h5,
		OP_MOV_A_PC = 4'h6,
		OP_IRQ_ENTRY = 4'h7,
		OP_IRQ_RETURN = 4'h8,
		OP_SP_LOAD = 4'h9
	} xac_op_t;

	typedef struct packed {
		xac_op_t op;
		logic [19:0] operand;
	} xac_cmd_t;

	typedef struct packed {
		logic [19:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} xac_mem_t;

	typedef struct packed {
		logic erase;
		logic prog;
		logic [1:0] seg;
		logic [5:0] offset;
		logic [7:0] wdata;
	} xac_flash_t;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_PUSH_A = 9'h002,
		ST_PUSH_B = 9'h004,
		ST_VEC_FETCH = 9'h008,
		ST_VEC_WAIT = 9'h010,
		ST_LOAD = 9'h020,
		ST_POP1 = 9'h040,
		ST_POP2 = 9'h080,
		ST_POP3 = 9'h100
	} xac_state_t;

endpackage

// ==== logic/xac_ctrl.sv ====
`timescale 1ns/100ps
module xac_ctrl #(
	parameter logic [19:0] SP_INIT = xac_pkg::SP_RESET,
	parameter logic [19:0] PC_INIT = xac_pkg::PC_RESET
) (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	// Flow command
	input wire logic CMD_VALID,
	input wire xac_pkg::xac_cmd_t CMD,
	input wire logic [xac_pkg::VEC_NUM_W-1:0] IRQ_NUM,
	input wire logic [15:0] STATUS_IN,
	output logic BUSY,
	output logic DONE,
	// Core state
	output logic [19:0] PROGRAM_COUNTER,
	output logic [19:0] STACK_POINTER,
	output logic [15:0] STATUS_OUT,
	output logic STATUS_LOAD,
	// Memory
	output xac_pkg::xac_mem_t MEM,
	input wire logic [15:0] MEM_RDATA,
	// Information flash
	input wire logic FLASH_REQ,
	input wire logic FLASH_ERASE,
	input wire logic [15:0] FLASH_ADDR,
	input wire logic [7:0] FLASH_WDATA,
	input wire logic UNLOCK_STB,
	input wire logic [15:0] UNLOCK_VALUE,
	output xac_pkg::xac_flash_t FLASH,
	output logic FLASH_REFUSED,
	output logic CAL_LOCKED
);

	// ****************************************
	// Flow control state
	// ****************************************
	xac_pkg::xac_state_t state_q, state_d;
	xac_pkg::xac_op_t op_q, op_d;
	logic [19:0] pc_q, pc_d;
	logic [19:0] sp_q, sp_d;
	logic [15:0] word_q, word_d;
	logic [4:0] vec_q, vec_d;
	logic [15:0] status_q, status_d;
	logic status_ld_q, status_ld_d;
	logic done_q, done_d;
	xac_pkg::xac_mem_t mem_q, mem_d;

	wire cmd_take = CMD_VALID && (state_q == xac_pkg::ST_IDLE);
	wire [19:0] sp_dec = sp_q - xac_pkg::STACK_STEP;
	wire [19:0] sp_inc = sp_q + xac_pkg::STACK_STEP;
	wire [19:0] vec_addr = xac_pkg::VEC_BASE_ADDR + {14'h0000, vec_q, 1'b0};
	wire [15:0] sr_packed = {pc_q[19:16], status_q[11:0]};
	wire [3:0] pc_hi = pc_q[19:16];

	// Program counter loads and pushed words, named once
	wire [15:0] pc_hi_word = {12'h000, pc_hi};
	wire [19:0] far_target = {vec_q[3:0], word_q};
	wire [19:0] vec_target = {xac_pkg::PC_HI_ZERO, MEM_RDATA};
	wire [19:0] far_return = {MEM_RDATA[3:0], word_q};
	wire [19:0] irq_return = {word_q[15:12], MEM_RDATA};

	always_comb begin
		state_d = state_q;
		op_d = op_q;
		pc_d = pc_q;
		sp_d = sp_q;
		word_d = word_q;
		vec_d = vec_q;
		status_d = status_q;
		status_ld_d = 1'b0;
		done_d = 1'b0;
		mem_d = '0;
		case (state_q)
			xac_pkg::ST_IDLE: begin
				if (cmd_take) begin
					op_d = CMD.op;
					case (CMD.op)
						xac_pkg::OP_NEAR_CALL: begin
							// Sixteen-bit return address only
							sp_d = sp_dec;
							mem_d = '{addr: sp_dec, wdata: pc_q[15:0], wr: 1'b1, rd: 1'b0};
							pc_d = {xac_pkg::PC_HI_ZERO, CMD.operand[15:0]};
							done_d = 1'b1;
						end
						xac_pkg::OP_FAR_CALL: begin
							// Upper bits go first, at the higher address
							sp_d = sp_dec;
							mem_d = '{addr: sp_dec, wdata: pc_hi_word, wr: 1'b1, rd: 1'b0};
							word_d = CMD.operand[15:0];
							vec_d = {1'b0, CMD.operand[19:16]};
							state_d = xac_pkg::ST_PUSH_B;
						end
						xac_pkg::OP_NEAR_RET,
						xac_pkg::OP_FAR_RET,
						xac_pkg::OP_IRQ_RETURN: begin
							sp_d = sp_inc;
							mem_d = '{addr: sp_q, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
							state_d = xac_pkg::ST_POP1;
						end
						xac_pkg::OP_MOV_W_PC: begin
							pc_d = {xac_pkg::PC_HI_ZERO, CMD.operand[15:0]};
							done_d = 1'b1;
						end
						xac_pkg::OP_MOV_A_PC: begin
							pc_d = CMD.operand;
							done_d = 1'b1;
						end
						xac_pkg::OP_IRQ_ENTRY: begin
							vec_d = IRQ_NUM;
							status_d = STATUS_IN;
							state_d = xac_pkg::ST_PUSH_A;
						end
						xac_pkg::OP_SP_LOAD: begin
							sp_d = CMD.operand;
							done_d = 1'b1;
						end
						default: begin
							done_d = 1'b1;
						end
					endcase
				end
			end
			xac_pkg::ST_PUSH_A: begin
				sp_d = sp_dec;
				mem_d = '{addr: sp_dec, wdata: pc_q[15:0], wr: 1'b1, rd: 1'b0};
				state_d = xac_pkg::ST_PUSH_B;
			end
			xac_pkg::ST_PUSH_B: begin
				sp_d = sp_dec;
				if (op_q == xac_pkg::OP_FAR_CALL) begin
					mem_d = '{addr: sp_dec, wdata: pc_q[15:0], wr: 1'b1, rd: 1'b0};
					pc_d = far_target;
					done_d = 1'b1;
					state_d = xac_pkg::ST_IDLE;
				end else begin
					// Upper program counter bits ride in the saved status word
					mem_d = '{addr: sp_dec, wdata: sr_packed, wr: 1'b1, rd: 1'b0};
					state_d = xac_pkg::ST_VEC_FETCH;
				end
			end
			xac_pkg::ST_VEC_FETCH: begin
				mem_d = '{addr: vec_addr, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
				state_d = xac_pkg::ST_VEC_WAIT;
			end
			xac_pkg::ST_VEC_WAIT: begin
				state_d = xac_pkg::ST_LOAD;
			end
			xac_pkg::ST_LOAD: begin
				// Vectors reach the first 64 KB only
				pc_d = vec_target;
				done_d = 1'b1;
				state_d = xac_pkg::ST_IDLE;
			end
			xac_pkg::ST_POP1: begin
				if (op_q != xac_pkg::OP_NEAR_RET) begin
					sp_d = sp_inc;
					mem_d = '{addr: sp_q, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
				end
				state_d = xac_pkg::ST_POP2;
			end
			xac_pkg::ST_POP2: begin
				if (op_q == xac_pkg::OP_NEAR_RET) begin
					pc_d = vec_target;
					done_d = 1'b1;
					state_d = xac_pkg::ST_IDLE;
				end else begin
					word_d = MEM_RDATA;
					state_d = xac_pkg::ST_POP3;
				end
			end
			xac_pkg::ST_POP3: begin
				done_d = 1'b1;
				state_d = xac_pkg::ST_IDLE;
				if (op_q == xac_pkg::OP_FAR_RET) begin
					pc_d = far_return;
				end else begin
					pc_d = irq_return;
					status_d = {4'h0, word_q[11:0]};
					status_ld_d = 1'b1;
				end
			end
			default: begin
				state_d = xac_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state_q <= xac_pkg::ST_IDLE;
			op_q <= xac_pkg::OP_NOP;
			pc_q <= PC_INIT;
			sp_q <= SP_INIT;
			word_q <= 16'h0000;
			vec_q <= 5'h00;
			status_q <= 16'h0000;
			status_ld_q <= 1'b0;
			done_q <= 1'b0;
			mem_q <= '0;
		end else begin
			state_q <= state_d;
			op_q <= op_d;
			pc_q <= pc_d;
			sp_q <= sp_d;
			word_q <= word_d;
			vec_q <= vec_d;
			status_q <= status_d;
			status_ld_q <= status_ld_d;
			done_q <= done_d;
			mem_q <= mem_d;
		end
	end

	// ****************************************
	// Information flash guard
	// ****************************************
	logic open_q;
	logic refused_q;
	xac_pkg::xac_flash_t flash_q;

	wire in_info = (FLASH_ADDR >= xac_pkg::INFO_BASE) && (FLASH_ADDR <= xac_pkg::INFO_LAST);
	wire [1:0] seg_sel = FLASH_ADDR[xac_pkg::INFO_OFS_W +: xac_pkg::INFO_SEG_W];
	wire [5:0] ofs_sel = FLASH_ADDR[xac_pkg::INFO_OFS_W-1:0];
	wire hits_a = (seg_sel == xac_pkg::SEG_A);
	wire key_ok = UNLOCK_STB && (UNLOCK_VALUE == xac_pkg::UNLOCK_KEY);
	wire grant = FLASH_REQ && in_info && (!hits_a || open_q);
	wire deny = FLASH_REQ && !grant;
	// One unlock covers one operation on segment A, then it relocks
	wire relock = FLASH_REQ && in_info && hits_a && open_q;
	// Set wins: an unlock alongside the relock keeps it open
	wire open_d = key_ok || (open_q && !relock);

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			open_q <= 1'b0;
			refused_q <= 1'b0;
			flash_q <= '0;
		end else begin
			open_q <= open_d;
			refused_q <= deny;
			flash_q.erase <= grant && FLASH_ERASE;
			flash_q.prog <= grant && !FLASH_ERASE;
			flash_q.seg <= seg_sel;
			flash_q.offset <= ofs_sel;
			flash_q.wdata <= FLASH_WDATA;
		end
	end

	// ****************************************
	// Registered status pins
	// ****************************************
	// Flags load their next-state values
	// Pin changes on the edge of the state it reports
	// Two flip-flops traded for no decode glitch on a pin
	logic busy_q;
	logic locked_q;
	wire busy_d = (state_d != xac_pkg::ST_IDLE);

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			busy_q <= 1'b0;
			locked_q <= 1'b1;
		end else begin
			busy_q <= busy_d;
			locked_q <= !open_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign BUSY = busy_q;
	assign DONE = done_q;
	assign PROGRAM_COUNTER = pc_q;
	assign STACK_POINTER = sp_q;
	assign STATUS_OUT = status_q;
	assign STATUS_LOAD = status_ld_q;
	assign MEM = mem_q;
	assign FLASH = flash_q;
	assign FLASH_REFUSED = refused_q;
	assign CAL_LOCKED = locked_q;

endmodule

// ==== test/xac_ctrl_properties.sv ====
`timescale 1ns/100ps
module xac_ctrl_properties (
	// Clock and reset
	input logic CORE_CLK,
	input logic SYS_RST,
	// Flow
	input logic CMD_VALID,
	input xac_pkg::xac_cmd_t CMD,
	input logic [xac_pkg::VEC_NUM_W-1:0] IRQ_NUM,
	input logic BUSY,
	input logic DONE,
	input logic [19:0] STACK_POINTER,
	input xac_pkg::xac_mem_t MEM,
	// Flash
	input logic FLASH_REQ,
	input logic [15:0] FLASH_ADDR,
	input xac_pkg::xac_flash_t FLASH,
	input logic FLASH_REFUSED,
	input logic CAL_LOCKED
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	wire take = CMD_VALID && !BUSY;
	wire in_info = FLASH_ADDR[15:8] == 8'h10;

	property p_far_call;
		take && CMD.op == xac_pkg::OP_FAR_CALL |=> MEM.wr && !DONE ##1 MEM.wr && DONE
			&& STACK_POINTER == $past(STACK_POINTER, 2) - 20'h00004;
	endproperty
	a_far_call: assert property (p_far_call) else $error("far call push wrong");
	property p_mov_w;
		take && CMD.op == xac_pkg::OP_MOV_W_PC |=> DONE;
	endproperty
	a_mov_w: assert property (p_mov_w) else $error("word move not single");
	property p_irq_entry;
		take && CMD.op == xac_pkg::OP_IRQ_ENTRY |=> !DONE [*5] ##1 DONE;
	endproperty
	a_irq_entry: assert property (p_irq_entry) else $error("entry length wrong");
	property p_irq_busy;
		take && CMD.op == xac_pkg::OP_IRQ_ENTRY |=> BUSY [*5] ##1 !BUSY && DONE;
	endproperty
	a_irq_busy: assert property (p_irq_busy) else $error("entry busy span wrong");
	property p_vec;
		take && CMD.op == xac_pkg::OP_IRQ_ENTRY |=> ##3 MEM.rd
			&& MEM.addr == xac_pkg::VEC_BASE_ADDR + {14'h0000, $past(IRQ_NUM, 4), 1'b0};
	endproperty
	a_vec: assert property (p_vec) else $error("vector address wrong");
	property p_irq_ret;
		take && CMD.op == xac_pkg::OP_IRQ_RETURN |=> !DONE [*3] ##1 DONE;
	endproperty
	a_irq_ret: assert property (p_irq_ret) else $error("return length wrong");
	property p_far_ret;
		take && CMD.op == xac_pkg::OP_FAR_RET |=> ##3 DONE
			&& STACK_POINTER == $past(STACK_POINTER, 4) + 20'h00004;
	endproperty
	a_far_ret: assert property (p_far_ret) else $error("far return stack wrong");
	property p_range;
		FLASH_REQ && !in_info |=> FLASH_REFUSED && !FLASH.erase && !FLASH.prog;
	endproperty
	a_range: assert property (p_range) else $error("outside flash granted");
	property p_seg;
		FLASH_REQ && in_info && FLASH_ADDR[7:6] != 2'h3 |=> !FLASH_REFUSED
			&& (FLASH.erase || FLASH.prog) && FLASH.seg == $past(FLASH_ADDR[7:6]);
	endproperty
	a_seg: assert property (p_seg) else $error("segment grant wrong");
	property p_lock;
		FLASH_REQ && CAL_LOCKED && FLASH_ADDR[15:6] == 10'h043 |=> FLASH_REFUSED;
	endproperty
	a_lock: assert property (p_lock) else $error("locked segment granted");
endmodule

// ==== test/xac_ctrl_tb.sv ====
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module xac_ctrl_tb;
	// ****************
	// Bench signals
	// ****************
	logic CORE_CLK = 0, SYS_RST = 1, CMD_VALID = 0, FLASH_REQ = 0, FLASH_ERASE = 0;
	logic UNLOCK_STB = 0, pend = 0, BUSY, DONE, STATUS_LOAD, FLASH_REFUSED, CAL_LOCKED;
	xac_pkg::xac_cmd_t CMD = '0;
	logic [4:0] IRQ_NUM = '0;
	logic [15:0] STATUS_IN = '0, MEM_RDATA = '0, FLASH_ADDR = '0, UNLOCK_VALUE = '0;
	logic [15:0] STATUS_OUT, mem [0:2047];
	logic [7:0] FLASH_WDATA = '0;
	logic [19:0] PROGRAM_COUNTER, STACK_POINTER;
	logic [10:0] pa = '0;
	xac_pkg::xac_mem_t MEM;
	xac_pkg::xac_flash_t FLASH;
	int bad_count = 0, n_tests = 0;

	always #5 CORE_CLK = ~CORE_CLK;
	xac_ctrl xac_ctrl_i (.CORE_CLK, .SYS_RST, .CMD_VALID, .CMD, .IRQ_NUM, .STATUS_IN, .BUSY,
		.DONE, .PROGRAM_COUNTER, .STACK_POINTER, .STATUS_OUT, .STATUS_LOAD, .MEM, .MEM_RDATA,
		.FLASH_REQ, .FLASH_ERASE, .FLASH_ADDR, .FLASH_WDATA, .UNLOCK_STB, .UNLOCK_VALUE,
		.FLASH, .FLASH_REFUSED, .CAL_LOCKED);

	// ****************
	// Memory
	// ****************
	always @(posedge CORE_CLK) if (MEM.wr) mem[MEM.addr[11:1]] <= MEM.wdata;
	// Data one cycle after the read; noise otherwise so stale data cannot pass
	always @(negedge CORE_CLK) begin
		MEM_RDATA <= pend ? mem[pa] : ~MEM_RDATA;
		pend <= MEM.rd;
		pa <= MEM.addr[11:1];
	end

	// ****************
	// Tasks
	// ****************
	task automatic final_report;
		$display("tests %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic run(input xac_pkg::xac_op_t op, input logic [19:0] arg, output int n);
		@(negedge CORE_CLK);
		CMD_VALID = 1;
		CMD = {op, arg};
		n = 0;
		do begin
			@(negedge CORE_CLK);
			CMD_VALID = 0;
			n++;
		end while (DONE !== 1'b1 && n < 20);
		if (n == 20) begin
			bad_count++;
			final_report();
		end
	endtask
	task automatic t_far;
		int n;
		run(xac_pkg::OP_MOV_A_PC, 20'h12344, n);
		`CHK("pc", 20'h12344, PROGRAM_COUNTER)
		run(xac_pkg::OP_FAR_CALL, 20'h5a5a0, n);
		`CHK("call cycles", 2, n)
		`CHK("pc", 20'h5a5a0, PROGRAM_COUNTER)
		run(xac_pkg::OP_FAR_RET, 20'h00000, n);
		`CHK("pc", 20'h12344, PROGRAM_COUNTER)
		`CHK("sp", 20'h00a00, STACK_POINTER)
		`CHK("stack hi", 16'h0001, mem[11'h4ff])
		`CHK("stack lo", 16'h2344, mem[11'h4fe])
	endtask
	task automatic t_near;
		int n;
		run(xac_pkg::OP_MOV_W_PC, 20'h3abcd, n);
		`CHK("pc", 20'h0abcd, PROGRAM_COUNTER)
		run(xac_pkg::OP_MOV_A_PC, 20'h4beef, n);
		run(xac_pkg::OP_NEAR_CALL, 20'h00100, n);
		`CHK("sp", 20'h009fe, STACK_POINTER)
		run(xac_pkg::OP_NEAR_RET, 20'h00000, n);
		`CHK("ret cycles", 3, n)
		`CHK("pc", 20'h0beef, PROGRAM_COUNTER)
		`CHK("stack", 16'hbeef, mem[11'h4ff])
		run(xac_pkg::OP_NOP, 20'h00000, n);
		`CHK("nop cycles", 1, n)
		`CHK("nop pc", 20'h0beef, PROGRAM_COUNTER)
		run(xac_pkg::OP_SP_LOAD, 20'h10c00, n);
		`CHK("sp load", 20'h10c00, STACK_POINTER)
		run(xac_pkg::OP_SP_LOAD, 20'h00a00, n);
		`CHK("sp load", 20'h00a00, STACK_POINTER)
	endtask
	// Reserved word holds a decoy so a wrong fetch shows in the program counter
	task automatic t_irq(input logic [4:0] v);
		int n;
		mem[{6'h3f, v}] = 16'h8000 + v;
		mem[11'h7df] = 16'hdead;
		IRQ_NUM = v;
		STATUS_IN = 16'hfab5;
		run(xac_pkg::OP_MOV_A_PC, 20'h71234, n);
		run(xac_pkg::OP_IRQ_ENTRY, 20'h00000, n);
		`CHK("entry cycles", 6, n)
		`CHK("status load", 1'b0, STATUS_LOAD)
		`CHK("vector pc", 20'h08000 + v, PROGRAM_COUNTER)
		run(xac_pkg::OP_IRQ_RETURN, 20'h00000, n);
		`CHK("return cycles", 4, n)
		`CHK("status load", 1'b1, STATUS_LOAD)
		`CHK("pc", 20'h71234, PROGRAM_COUNTER)
		`CHK("status", 16'h0ab5, STATUS_OUT)
		`CHK("stacked sr", 16'h7ab5, mem[11'h4fe])
	endtask
	task automatic fl(input logic er, input logic [15:0] a, input logic ok);
		@(negedge CORE_CLK);
		FLASH_REQ = 1;
		FLASH_ERASE = er;
		FLASH_ADDR = a;
		FLASH_WDATA = a[7:0] ^ 8'ha5;
		@(negedge CORE_CLK);
		FLASH_REQ = 0;
		`CHK("refused", !ok, FLASH_REFUSED)
		`CHK("erase", er & ok, FLASH.erase)
		`CHK("program", !er & ok, FLASH.prog)
		if (ok) `CHK("segment", a[7:6], FLASH.seg)
		`CHK("offset", a[5:0], FLASH.offset)
		`CHK("wdata", a[7:0] ^ 8'ha5, FLASH.wdata)
	endtask
	task automatic unlock(input logic [15:0] k);
		@(negedge CORE_CLK);
		UNLOCK_STB = 1;
		UNLOCK_VALUE = k;
		@(negedge CORE_CLK);
		UNLOCK_STB = 0;
	endtask
	task automatic t_flash;
		for (int i = 0; i < 3; i++) fl(1'b1, 16'(16'h1000 + 16'h0040 * i), 1'b1);
		fl(1'b1, 16'h0fff, 1'b0);
		fl(1'b0, 16'h1100, 1'b0);
		fl(1'b1, 16'h10c0, 1'b0);
		unlock(~xac_pkg::UNLOCK_KEY);
		`CHK("locked", 1'b1, CAL_LOCKED)
		unlock(xac_pkg::UNLOCK_KEY);
		`CHK("locked", 1'b0, CAL_LOCKED)
		fl(1'b0, 16'h10ff, 1'b1);
		@(negedge CORE_CLK);
		`CHK("relocked", 1'b1, CAL_LOCKED)
		fl(1'b1, 16'h10c0, 1'b0);
	endtask

	initial begin
		repeat (10) @(negedge CORE_CLK);
		SYS_RST = 0;
		`CHK("sp", 20'h00a00, STACK_POINTER)
		`CHK("locked", 1'b1, CAL_LOCKED)
		t_far();
		t_near();
		t_irq(5'h00);
		t_irq(5'h1f);
		t_flash();
		final_report();
	end
endmodule

bind xac_ctrl xac_ctrl_properties xac_ctrl_properties_i (.CORE_CLK, .SYS_RST, .CMD_VALID,
	.CMD, .IRQ_NUM, .BUSY, .DONE, .STACK_POINTER, .MEM, .FLASH_REQ, .FLASH_ADDR, .FLASH,
	.FLASH_REFUSED, .CAL_LOCKED);
